//--- core/ipe_port.sv
// programming port entry: session gating and serial-clock frame logic
`timescale 1ns/1ps
// Functional notes
// - programmer is master, device only slave
// - mode 0 only, serial clock up to 5 MHz
// - programming only while reset pin low
// - link logic runs from serial clock only
// - reset-as-io still resets at power-up
// - io mode stays programming until pin high
// - io mode needs power cycle for next session
// - fuse set: entry on any reset
// - fuse clear: entry only at power-on
// - select rising edge completes a command
// - packets need aa 55 preamble
// - commands on data-in, answers on data-out
// - program-enable must be first command
module ipe_port
    import ipe_pkg::*;
(
    // system clock domain
    input  wire logic       clk,
    input  wire logic       rst,
    // device state and configuration
    input  wire logic       por_active,
    input  wire logic       rst_pin_n,
    input  wire logic       rst_as_io,
    input  wire logic       prog_fuse_en,
    // serial link pins (own clock)
    input  wire logic       sck,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic            miso_oe,
    // status toward the rest of the device
    output logic            prog_mode,
    output logic            prog_enabled,
    output logic            cmd_valid,
    output logic [7:0]      cmd_opcode,
    // answer byte from the command unit
    input  wire logic [7:0] reply_byte
);
    // ==========================================================
    // system domain: input synchronisers
    // ==========================================================
    logic rst_pin_s;   // synchronised reset pin level
    logic ss_s;        // synchronised select level
    logic done_tgl_s;  // synchronised command toggle
    logic ena_tgl_s;   // synchronised enable toggle

    // pin and select idle high, so their chains reset high: a low reset value would fake an entry
    ipe_sync #(.RST_VAL(1'b1)) u_sync_rst (.clk(clk), .rst(rst), .din(rst_pin_n),  .dout(rst_pin_s));
    ipe_sync #(.RST_VAL(1'b1)) u_sync_ss  (.clk(clk), .rst(rst), .din(ss_n),       .dout(ss_s));
    logic       done_tgl_q;  // serial-domain toggle, one per accepted command
    logic       ena_tgl_q;   // serial-domain toggle, one per program-enable
    logic [7:0] op_q;        // opcode byte of the frame, written in the serial domain
    ipe_sync u_sync_cmd (.clk(clk), .rst(rst), .din(done_tgl_q), .dout(done_tgl_s));
    ipe_sync u_sync_ena (.clk(clk), .rst(rst), .din(ena_tgl_q),  .dout(ena_tgl_s));

    // ==========================================================
    // system domain: session state machine
    // ==========================================================
    ipe_state_t state_q;     // session state
    logic       io_sess_q;   // session began at power-on in io mode
    logic       io_used_q;   // an io-mode session already ended

    // entry needs the pin low; at power-on always, later only with the fuse
    function automatic logic entry_ok(input logic pin_low, input logic por, input logic fuse);
        entry_ok = pin_low && (por || fuse);
    endfunction : entry_ok

    // the pin is a reset during power-up even when used as io
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q   <= IPE_ST_RUN;
            io_sess_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                IPE_ST_RUN:
                begin
                    // io mode enters only at power-on
                    if (rst_as_io)
                    begin
                        if (!io_used_q && por_active && !rst_pin_s)
                        begin
                            state_q   <= IPE_ST_PROG;
                            io_sess_q <= 1'b1;
                        end
                    end
                    else if (entry_ok(!rst_pin_s, por_active, prog_fuse_en))
                    begin
                        state_q   <= IPE_ST_PROG;
                        io_sess_q <= 1'b0;
                    end
                end
                IPE_ST_PROG:
                begin
                    // leave only when pin goes high
                    if (rst_pin_s)
                        state_q <= io_sess_q ? IPE_ST_DONE : IPE_ST_RUN;
                end
                IPE_ST_DONE:
                begin
                    // stays here until power is cycled (system reset)
                    state_q <= IPE_ST_DONE;
                end
                default:
                    state_q <= IPE_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            io_used_q <= 1'b0;
        else if (state_q == IPE_ST_DONE)
            io_used_q <= 1'b1;
    end

    assign prog_mode = (state_q == IPE_ST_PROG);

    // ==========================================================
    // system domain: command and enable events
    // ==========================================================
    logic done_seen_q;  // last seen command toggle
    logic ena_seen_q;   // last seen enable toggle
    logic en_q;         // program-enable received this session
    logic cmd_pend;     // new command toggle seen

    assign cmd_pend = done_tgl_s ^ done_seen_q;

    // edge detect on synchronised toggles
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            done_seen_q <= 1'b0;
            ena_seen_q  <= 1'b0;
        end
        else
        begin
            done_seen_q <= done_tgl_s;
            ena_seen_q  <= ena_tgl_s;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || !prog_mode)
            en_q <= 1'b0;
        else if (ena_tgl_s ^ ena_seen_q)
            en_q <= 1'b1;
    end
    assign prog_enabled = en_q;

    // command reported after select rises
    // opcode word is stable: captured before the toggle and held until the opcode byte of the next frame
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cmd_valid  <= 1'b0;
            cmd_opcode <= 8'h00;
        end
        else
        begin
            cmd_valid <= cmd_pend && prog_mode && en_q && ss_s;
            if (cmd_pend)
                cmd_opcode <= op_q;
        end
    end

    // ==========================================================
    // serial domain: shift logic on the serial clock
    // ==========================================================
    logic [2:0] bit_q;     // bit index within byte
    logic [7:0] sh_q;      // receive shift register
    logic [2:0] byte_q;    // header bytes received, saturating
    logic       bad_q;     // preamble or key mismatch in this frame
    logic [7:0] tx_q;      // transmit shift register
    logic [7:0] rx_byte;   // byte completing on this edge
    logic       frame_ok;  // full header seen without mismatch

    assign rx_byte  = {sh_q[6:0], mosi};
    assign frame_ok = (byte_q == IPE_HDR_BYTES) && !bad_q;

    // link runs from serial clock alone
    // commands arrive on data-in
    // select high clears the counters and keeps them at zero; no edge is needed after the frame
    always_ff @(posedge sck or posedge ss_n)
    begin
        if (ss_n)
        begin
            bit_q  <= 3'h0;
            sh_q   <= 8'h00;
            byte_q <= 3'h0;
            bad_q  <= 1'b0;
        end
        else
        begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= rx_byte;
            if (bit_q == IPE_BIT_LAST && byte_q != IPE_HDR_BYTES)
            begin
                byte_q <= byte_q + 3'h1;
                unique case (byte_q)
                    3'h0:    bad_q <= bad_q | (rx_byte != IPE_PRE0);
                    3'h1:    bad_q <= bad_q | (rx_byte != IPE_PRE1);
                    3'h3:    bad_q <= bad_q | ((op_q == IPE_OP_ENABLE) && (rx_byte != IPE_EN_KEY));
                    default: bad_q <= bad_q;
                endcase
            end
        end
    end

    // opcode held across select high so the system side reads it steadily
    always_ff @(posedge sck)
    begin
        if (!ss_n && bit_q == IPE_BIT_LAST && byte_q == 3'h2)
            op_q <= rx_byte;
    end

    // short or bad frames discarded
    // toggles clear with the device reset, in step with their synchronisers,
    // so a stale toggle level never reads as a pending command after reset
    always_ff @(posedge ss_n or posedge rst)
    begin
        if (rst)
        begin
            done_tgl_q <= 1'b0;
            ena_tgl_q  <= 1'b0;
        end
        else
        begin
            if (frame_ok && prog_mode)
                done_tgl_q <= ~done_tgl_q;
            if (frame_ok && prog_mode && op_q == IPE_OP_ENABLE)
                ena_tgl_q <= ~ena_tgl_q;
        end
    end

    // answers on data-out, falling edge launch
    // drive only when selected in programming mode
    always_ff @(negedge sck or posedge ss_n)
    begin
        if (ss_n)
            tx_q <= IPE_IDLE_OUT;
        else if (bit_q == 3'h0)
            tx_q <= reply_byte;
        else
            tx_q <= {tx_q[6:0], 1'b1};
    end

    assign miso    = tx_q[7];
    assign miso_oe = !ss_n && prog_mode;
endmodule : ipe_port

//--- include/ipe_pkg.sv
// shared constants for the programming port entry block
package ipe_pkg;
    // ==========================================================
    // framing and command constants
    // ==========================================================
    localparam logic [7:0] IPE_PRE0       = 8'haa;  // first preamble byte
    localparam logic [7:0] IPE_PRE1       = 8'h55;  // second preamble byte
    localparam logic [7:0] IPE_OP_ENABLE  = 8'hac;  // program-enable opcode
    localparam logic [7:0] IPE_EN_KEY     = 8'h53;  // program-enable second byte
    localparam logic [2:0] IPE_BIT_LAST   = 3'h7;   // last bit index of a byte
    localparam logic [2:0] IPE_HDR_BYTES  = 3'h4;   // preamble + opcode + key
    localparam logic [7:0] IPE_IDLE_OUT   = 8'hff;  // data-out value when idle
    // ==========================================================
    // timing: serial clock limit and system clock rate
    // ==========================================================
    localparam int IPE_SYS_CLK_HZ   = 10_000_000;   // system clock rate
    localparam int IPE_SCK_MAX_HZ   = 5_000_000;    // highest serial clock rate
    // session states (system clock domain)
    typedef enum logic [1:0] {IPE_ST_RUN, IPE_ST_PROG, IPE_ST_DONE} ipe_state_t;
endpackage : ipe_pkg

//--- core/ipe_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module ipe_sync
    import ipe_pkg::*;
#(
    // level shown while reset is held; match the idle level of the input
    parameter logic RST_VAL = 1'b0
)
(
    // clocking
    input  wire logic clk,
    input  wire logic rst,
    // level in and out
    input  wire logic din,
    output logic      dout
);
    // ==========================================================
    // synchroniser chain
    // ==========================================================
    logic meta_q;  // first stage, read only by the second stage
    // both stages take the idle level on reset so no false edge follows release
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            dout   <= RST_VAL;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : ipe_sync

//--- dv/ipe_port_properties.sv
// assertion checker for the programming port entry block
`timescale 1ns/1ps
module ipe_port_properties
    import ipe_pkg::*;
(
    // system side
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       por_active,
    input wire logic       rst_pin_n,
    input wire logic       rst_as_io,
    input wire logic       prog_fuse_en,
    // link pins
    input wire logic       sck,
    input wire logic       ss_n,
    input wire logic       mosi,
    input wire logic       miso,
    input wire logic       miso_oe,
    // status and reply
    input wire logic       prog_mode,
    input wire logic       prog_enabled,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [7:0] reply_byte
);
    // ==========
    // helper: io session lock, set once an io session has ended
    logic lock_q;
    always_ff @(posedge clk)
    begin
        if (rst)
            lock_q <= 1'b0;
        else if (rst_as_io && $fell(prog_mode))
            lock_q <= 1'b1;
    end
    // ==========
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // pin levels held long enough to pass the synchroniser
    sequence s_pin_low; !rst_pin_n [*3]; endsequence
    sequence s_pin_high; rst_pin_n [*4]; endsequence
    property p_oe; miso_oe == (!ss_n && prog_mode); endproperty
    a_oe: assert property (p_oe) else $error("miso_oe wrong");
    property p_exit; $rose(rst_pin_n) |-> ##[1:4] !prog_mode; endproperty
    a_exit: assert property (p_exit) else $error("no exit");
    property p_noentry; s_pin_high ##0 !prog_mode |=> !prog_mode; endproperty
    a_noentry: assert property (p_noentry) else $error("entry with pin high");
    property p_stay; s_pin_low ##0 prog_mode |=> prog_mode; endproperty
    a_stay: assert property (p_stay) else $error("left session");
    property p_fuse; (!rst_pin_n && prog_fuse_en && !rst_as_io) [*5] |-> prog_mode; endproperty
    a_fuse: assert property (p_fuse) else $error("no entry with fuse");
    property p_por; (!prog_fuse_en && !por_active) [*2] ##0 !prog_mode |=> !prog_mode; endproperty
    a_por: assert property (p_por) else $error("entry after power-on");
    property p_cmd; cmd_valid |-> prog_enabled && ss_n && $past(ss_n, 3) ##1 !cmd_valid; endproperty
    a_cmd: assert property (p_cmd) else $error("bad command pulse");
    property p_lock; lock_q |-> !prog_mode; endproperty
    a_lock: assert property (p_lock) else $error("io session reentered");
endmodule : ipe_port_properties

bind ipe_port ipe_port_properties u_ipe_port_properties
(
    .clk          (clk),
    .rst          (rst),
    .por_active   (por_active),
    .rst_pin_n    (rst_pin_n),
    .rst_as_io    (rst_as_io),
    .prog_fuse_en (prog_fuse_en),
    .sck          (sck),
    .ss_n         (ss_n),
    .mosi         (mosi),
    .miso         (miso),
    .miso_oe      (miso_oe),
    .prog_mode    (prog_mode),
    .prog_enabled (prog_enabled),
    .cmd_valid    (cmd_valid),
    .cmd_opcode   (cmd_opcode),
    .reply_byte   (reply_byte)
);

//--- dv/ipe_prog_model.sv
// programmer model: link master in clock mode 0
`timescale 1ns/1ps
module ipe_prog_model
(
    // link pins
    output logic      sck,
    output logic      ss_n,
    output logic      mosi,
    input  wire logic miso
);
    // ==========
    logic [7:0] rx;  // last eight bits taken from data-out
    // clock idles low, select defined
    // the select rises once after start: the link counters and shift registers have no other reset
    initial
    begin
        sck = 1'b0;
        ss_n = 1'b0;
        mosi = 1'b0;
        rx = 8'h00;
        #1 ss_n = 1'b1;
    end
    // framed msb-first bytes, clock runs only in frames
    task send(input logic [39:0] pkt, input int nb);
        ss_n = 1'b0;
        for (int i = 39; i > 39 - nb * 8; i--)
        begin
            mosi = pkt[i];
            #16 sck = 1'b1;
            // master samples data-out on the rising edge, mode 0
            rx = {rx[6:0], miso};
            #16 sck = 1'b0;
        end
        #16 ss_n = 1'b1;
        // released line shows the inverse so a stale bit is never trusted
        mosi = ~mosi;
    endtask : send
endmodule : ipe_prog_model

//--- dv/tb_top.sv
// self-checking bench for the programming port entry block
`timescale 1ns/1ps
module tb_top
    import ipe_pkg::*;
;
    // ==========
    logic       clk, rst, por_active, rst_pin_n, rst_as_io, prog_fuse_en;
    logic       sck, ss_n, mosi, miso, miso_oe;
    logic       prog_mode, prog_enabled, cmd_valid;
    logic [7:0] cmd_opcode, reply_byte;
    int         miscompares = 0, cmp_count = 0, cyc = 0, nvalid = 0;
    ipe_port u_ipe_port
    (
        .clk          (clk),
        .rst          (rst),
        .por_active   (por_active),
        .rst_pin_n    (rst_pin_n),
        .rst_as_io    (rst_as_io),
        .prog_fuse_en (prog_fuse_en),
        .sck          (sck),
        .ss_n         (ss_n),
        .mosi         (mosi),
        .miso         (miso),
        .miso_oe      (miso_oe),
        .prog_mode    (prog_mode),
        .prog_enabled (prog_enabled),
        .cmd_valid    (cmd_valid),
        .cmd_opcode   (cmd_opcode),
        .reply_byte   (reply_byte)
    );
    ipe_prog_model u_ipe_prog_model
    (
        .sck  (sck),
        .ss_n (ss_n),
        .mosi (mosi),
        .miso (miso)
    );
    // ==========
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // cycle ceiling and command pulse count, looked at mid-cycle where outputs are settled
    always @(negedge clk)
    begin
        cyc++;
        if (cmd_valid === 1'b1)
            nvalid++;
        if (cyc > 20000)
        begin
            miscompares++;
            finish_test();
        end
    end
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task cyc_n(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc_n
    // one frame, then the gap the link needs before the next
    task frame(input logic [39:0] p, input int nb);
        u_ipe_prog_model.send(p, nb);
        cyc_n(10);
    endtask : frame
    // ==========
    task t_por();
        rst_pin_n = 1'b0;
        cyc_n(5);
        cmp(8'(prog_mode), 8'h01);
        cmp(8'(miso), 8'h01);
        frame({IPE_PRE0, IPE_PRE1, 8'h30, 16'h0000}, 4);
        frame({IPE_PRE0, IPE_PRE1, IPE_OP_ENABLE, 8'h52, 8'h00}, 4);
        cmp(8'(prog_enabled), 8'h00);
        frame({IPE_PRE0, IPE_PRE1, IPE_OP_ENABLE, IPE_EN_KEY, 8'h00}, 4);
        cmp(8'(prog_enabled), 8'h01);
        frame({IPE_PRE0, 8'h54, 8'h30, 16'h0000}, 4);
        frame({IPE_PRE0, IPE_PRE1, 8'h30, 16'h0000}, 3);
        cmp(8'(nvalid), 8'h00);
        frame({IPE_PRE0, IPE_PRE1, 8'h30, 16'h0000}, 5);
        cmp(8'(nvalid), 8'h01);
        cmp(cmd_opcode, 8'h30);
        cmp(u_ipe_prog_model.rx, 8'h5a);
        $display("test por done");
    endtask : t_por
    task t_fuse();
        rst_pin_n = 1'b1;
        por_active = 1'b0;
        cyc_n(6);
        cmp(8'(prog_mode), 8'h00);
        rst_pin_n = 1'b0;
        cyc_n(6);
        cmp(8'(prog_mode), 8'h00);
        prog_fuse_en = 1'b1;
        cyc_n(6);
        cmp(8'(prog_mode), 8'h01);
        cmp(8'(prog_enabled), 8'h00);
        $display("test fuse done");
    endtask : t_fuse
    task t_io();
        rst_pin_n = 1'b1;
        rst = 1'b1;
        rst_as_io = 1'b1;
        por_active = 1'b1;
        cyc_n(3);
        rst = 1'b0;
        rst_pin_n = 1'b0;
        cyc_n(6);
        por_active = 1'b0;
        cyc_n(6);
        cmp(8'(prog_mode), 8'h01);
        rst_pin_n = 1'b1;
        cyc_n(6);
        rst_pin_n = 1'b0;
        cyc_n(6);
        cmp(8'(prog_mode), 8'h00);
        $display("test io done");
    endtask : t_io
    task finish_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // ==========
    initial
    begin
        rst = 1'b1;
        por_active = 1'b1;
        rst_pin_n = 1'b1;
        rst_as_io = 1'b0;
        prog_fuse_en = 1'b0;
        reply_byte = 8'h5a;
        cyc_n(10);
        rst = 1'b0;
        t_por();
        t_fuse();
        t_io();
        finish_test();
    end
endmodule : tb_top
